// *** design/rxcs_pkg.sv ***
// rxcs_pkg: register map, field positions, reset values and timing counts
// of the receive clock source and signal loss block.
// assumes a 25 MHz system clock; all line-side inputs are asynchronous.
package rxcs_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INT_CLEAR = 4'h3;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h4;

  localparam int CTRL_ALARM_EN = 0;
  localparam int CTRL_CDR_BYPASS = 1;
  localparam int CTRL_PATT_MCLK = 2;
  localparam int CTRL_FALL_EDGE = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] INT_RESET = 4'h0;

  localparam int EV_LOS_SET = 0;
  localparam int EV_LOS_CLR = 1;
  localparam int EV_TX_MISS = 2;
  localparam int EV_MCLK_LOSS = 3;
  localparam int NUM_EV = 4;

  localparam int SYNC_W = 10;

  // tx line clock stuck for more than this many master reference cycles
  localparam logic [6:0] TX_MISS_MCLK_CYCLES = 7'h46;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int MCLK_LOSS_NS = 2000;
  localparam int MCLK_LOSS_CYCLES = (MCLK_LOSS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {
    RXCS_IF_HW,
    RXCS_IF_SERIAL,
    RXCS_IF_MOTOROLA,
    RXCS_IF_INTEL
  } rxcs_ctrl_if_t;

  typedef enum logic [1:0] {
    RXCS_SRC_RECOVERED,
    RXCS_SRC_MCLK,
    RXCS_SRC_SLICER
  } rxcs_src_t;
endpackage : rxcs_pkg

// *** design/rxcs_top.sv ***
// rxcs_top: receive clock selection, tx clock and master clock supervision,
// signal loss output and control interface strap decode.
// assumes every line-side input is asynchronous to clock and slow against it;
// the register port is driven from logic on clock.
`timescale 1ns/1ps

// Notes on behaviour
// - tx clock missing after over 70 mclk
// - rx clock rate follows line standard
// - loss with alarm enable: rx clock from mclk
// - recovery active: rx clock is recovered clock
// - rx data launched on active rx edge
// - recovery bypassed: rx clock is rail xor
// - mclk is recovery and interface reference
// - patterns timed by mclk when chosen
// - forced alarm patterns always use mclk; tx all ones and prbs use it only in hardware mode
// - mclk lost: tx line outputs released
// - loss output high while signal lost
// - loss output falls by itself
// - select pins 00 give hardware control
// - 01 serial, 10 motorola, 11 intel
// - hardware mode: edge pin low is rising
module rxcs_top
  import rxcs_pkg::*;
#(
  parameter int MCLK_LOSS = MCLK_LOSS_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic mclk_in,
  input wire logic tx_line_clock,
  input wire logic rx_recovered_clock,
  input wire logic rx_signal_lost,
  input wire logic rx_data_in,
  input wire logic rx_positive_rail_in,
  input wire logic rx_negative_rail_in,
  input wire logic [1:0] ctrl_if_select,
  input wire logic rx_edge_select,
  input wire logic auto_all_ones_send,
  input wire logic all_ones_alarm,
  input wire logic transmit_all_ones,
  input wire logic prbs_send,
  output logic rx_clock,
  output logic rx_data,
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic los,
  output logic tx_clock_missing,
  output logic mclk_lost,
  output logic tx_line_oe,
  output rxcs_ctrl_if_t ctrl_if_mode,
  output logic mclk_ref_tick,
  output logic pattern_tick,
  output logic pattern_uses_mclk
);

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic mclk_d;
  logic tx_line_clock_d;
  logic [7:0] ctrl;
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] int_enable;
  logic [6:0] tx_line_clock_cnt;
  logic [15:0] mclk_idle;
  logic [1:0] strap_wait;
  logic [7:0] read_mux;

  // one strobe and address decode shared by every register write; reads decode addr alone
  function automatic logic reg_hit(input logic strobe, input logic [3:0] a, input logic [3:0] target);
    reg_hit = strobe && (a == target);
  endfunction : reg_hit

  assign async_in = {mclk_in, tx_line_clock, rx_recovered_clock, rx_signal_lost, rx_data_in,
                     rx_positive_rail_in, rx_negative_rail_in, rx_edge_select, ctrl_if_select};

  // two flops per line-side input; only the second flop feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= async_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  wire mclk_s = sync2[9];
  wire tx_line_clock_s = sync2[8];
  wire rec_s = sync2[7];
  wire lost_s = sync2[6];
  wire rd_s = sync2[5];
  wire rp_s = sync2[4];
  wire rn_s = sync2[3];
  wire edge_pin_s = sync2[2];
  wire [1:0] sel_s = sync2[1:0];

  wire mclk_rise = mclk_s & ~mclk_d;
  wire mclk_edge = mclk_s ^ mclk_d;
  wire tx_line_clock_edge = tx_line_clock_s ^ tx_line_clock_d;
  wire tx_line_clock_rise = tx_line_clock_s & ~tx_line_clock_d;

  // tx clock supervision counts master reference cycles, not system cycles
  wire [6:0] next_tx_line_clock_cnt = tx_line_clock_edge ? 7'h00 :
                             (mclk_rise && tx_line_clock_cnt <= TX_MISS_MCLK_CYCLES) ? tx_line_clock_cnt + 7'h01 : tx_line_clock_cnt;
  wire next_tx_miss = next_tx_line_clock_cnt > TX_MISS_MCLK_CYCLES;

  wire [15:0] next_mclk_idle = mclk_edge ? 16'h0000 :
                               (mclk_idle < 16'(MCLK_LOSS)) ? mclk_idle + 16'h0001 : mclk_idle;
  wire next_mclk_lost = next_mclk_idle >= 16'(MCLK_LOSS);

  wire hw_mode = ctrl_if_mode == RXCS_IF_HW;
  wire fall_sel = hw_mode ? edge_pin_s : ctrl[CTRL_FALL_EDGE];

  // loss with alarm enable outranks bypass: a dead line gives no rail edges anyway
  wire [1:0] src_sel = (lost_s && ctrl[CTRL_ALARM_EN]) ? RXCS_SRC_MCLK :
                       ctrl[CTRL_CDR_BYPASS] ? RXCS_SRC_SLICER : RXCS_SRC_RECOVERED;
  // rate is that of the chosen source, so the line standard sets it
  wire next_rx_clock = (src_sel == RXCS_SRC_MCLK) ? mclk_s :
                       (src_sel == RXCS_SRC_SLICER) ? (rp_s ^ rn_s) : rec_s;
  wire launch = (next_rx_clock != rx_clock) && (next_rx_clock != fall_sel);

  wire next_uses_mclk = ctrl[CTRL_PATT_MCLK] | auto_all_ones_send | all_ones_alarm |
                        (hw_mode & (transmit_all_ones | prbs_send));

  wire ev_los_set = lost_s & ~los;
  wire ev_los_clr = ~lost_s & los;
  wire [NUM_EV-1:0] events = {next_mclk_lost & ~mclk_lost, next_tx_miss & ~tx_clock_missing,
                              ev_los_clr, ev_los_set};
  wire clear_hit = reg_hit(wr_en, addr, ADDR_INT_CLEAR);
  wire ctrl_hit = reg_hit(wr_en, addr, ADDR_CTRL);
  wire enable_hit = reg_hit(wr_en, addr, ADDR_INT_ENABLE);
  wire [NUM_EV-1:0] clear_mask = clear_hit ? wdata[NUM_EV-1:0] : INT_RESET;
  // a new event in the clear cycle stays set
  wire [NUM_EV-1:0] next_int_status = (int_status & ~clear_mask) | events;
  wire [NUM_EV-1:0] next_int_enable = enable_hit ? wdata[NUM_EV-1:0] : int_enable;

  wire [7:0] status_word = {2'h0, ctrl_if_mode, 1'b0, mclk_lost, tx_clock_missing, los};
  // the clear register is write-only and reads as zero like any hole
  always_comb begin
    if (addr == ADDR_CTRL) begin
      read_mux = ctrl;
    end else if (addr == ADDR_STATUS) begin
      read_mux = status_word;
    end else if (addr == ADDR_INT_STATUS) begin
      read_mux = {4'h0, int_status};
    end else if (addr == ADDR_INT_ENABLE) begin
      read_mux = {4'h0, int_enable};
    end else begin
      read_mux = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mclk_d <= 1'b0;
      tx_line_clock_d <= 1'b0;
      tx_line_clock_cnt <= 7'h00;
      mclk_idle <= 16'h0000;
      tx_clock_missing <= 1'b0;
      mclk_lost <= 1'b0;
      tx_line_oe <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      tx_line_clock_d <= tx_line_clock_s;
      tx_line_clock_cnt <= next_tx_line_clock_cnt;
      mclk_idle <= next_mclk_idle;
      tx_clock_missing <= next_tx_miss;
      mclk_lost <= next_mclk_lost;
      tx_line_oe <= ~next_mclk_lost;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_clock <= 1'b0;
      rx_data <= 1'b0;
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      los <= 1'b0;
    end else begin
      rx_clock <= next_rx_clock;
      los <= lost_s;
      if (launch) begin
        rx_data <= rd_s;
        rx_positive_rail <= rp_s;
        rx_negative_rail <= rn_s;
      end
    end
  end

  // straps are caught once the synchronisers hold real pin levels
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_wait <= 2'h0;
      ctrl_if_mode <= RXCS_IF_HW;
    end else begin
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
      end
      if (strap_wait == STRAP_WAIT) begin
        ctrl_if_mode <= rxcs_ctrl_if_t'(sel_s);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mclk_ref_tick <= 1'b0;
      pattern_tick <= 1'b0;
      pattern_uses_mclk <= 1'b0;
    end else begin
      mclk_ref_tick <= mclk_rise;
      pattern_uses_mclk <= next_uses_mclk;
      pattern_tick <= next_uses_mclk ? mclk_rise : tx_line_clock_rise;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      int_status <= INT_RESET;
      int_enable <= INT_RESET;
      irq <= 1'b0;
      rdata <= 8'h00;
    end else begin
      if (ctrl_hit) begin
        ctrl <= wdata;
      end
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      irq <= |(next_int_status & next_int_enable);
      rdata <= rd_en ? read_mux : 8'h00;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_tx_miss_count: assert property ($rose(tx_clock_missing) |-> tx_line_clock_cnt == TX_MISS_MCLK_CYCLES + 7'h01)
    else $error("tx clock missing raised at wrong count");
  a_tx_miss_clear: assert property (tx_line_clock_edge |=> !tx_clock_missing)
    else $error("tx clock missing kept after a tx clock edge");
  a_rx_src_mclk: assert property (src_sel == RXCS_SRC_MCLK |=> rx_clock == $past(mclk_s))
    else $error("rx clock not taken from master reference");
  a_rx_src_rec: assert property (src_sel == RXCS_SRC_RECOVERED |=> rx_clock == $past(rec_s))
    else $error("rx clock not taken from recovered clock");
  a_rx_src_xor: assert property (src_sel == RXCS_SRC_SLICER |=> rx_clock == $past(rp_s ^ rn_s))
    else $error("rx clock not the rail xor");
  a_launch_edge: assert property (!launch |=> $stable(rx_data) && $stable(rx_positive_rail) && $stable(rx_negative_rail))
    else $error("rx data moved off the active edge");
  a_launch_data: assert property (launch |=> rx_data == $past(rd_s) && rx_clock != $past(fall_sel))
    else $error("rx data not launched on active edge");
  a_los_follow: assert property (lost_s ##1 lost_s |-> los)
    else $error("loss output low while signal lost");
  a_los_release: assert property (!lost_s |=> !los)
    else $error("loss output stayed high");
  a_tx_oe_off: assert property (mclk_lost |-> !tx_line_oe)
    else $error("tx line driven with master clock lost");
  a_pattern_ref: assert property (next_uses_mclk && mclk_rise |=> pattern_tick && pattern_uses_mclk)
    else $error("pattern tick missed a master clock edge");
  a_forced_mclk: assert property (all_ones_alarm || auto_all_ones_send |=> pattern_uses_mclk)
    else $error("forced pattern not on master clock");
  a_strap_mode: assert property (strap_wait == STRAP_WAIT |=> ctrl_if_mode == rxcs_ctrl_if_t'($past(sel_s)))
    else $error("control interface strap not captured");
  a_set_wins: assert property (ev_los_set && clear_hit |=> int_status[EV_LOS_SET])
    else $error("event lost under clear");
  a_irq_level: assert property (##1 irq == |(int_status & int_enable))
    else $error("interrupt not tied to enabled status");

  // clock supervision: flags follow their counters and raise their events
  a_tx_miss_level: assert property (tx_line_clock_cnt <= TX_MISS_MCLK_CYCLES |-> !tx_clock_missing)
    else $error("tx clock missing raised early");
  a_tx_miss_hold: assert property (tx_clock_missing && !tx_line_clock_edge |=> tx_clock_missing)
    else $error("tx clock missing dropped without a tx clock edge");
  a_miss_event: assert property ($rose(tx_clock_missing) |-> int_status[EV_TX_MISS])
    else $error("tx missing event not recorded");
  a_mclk_lost_set: assert property (mclk_idle >= 16'(MCLK_LOSS) |-> mclk_lost && !tx_line_oe)
    else $error("master clock loss not flagged");
  a_mclk_edge_back: assert property (mclk_edge |=> !mclk_lost && tx_line_oe)
    else $error("tx line not driven after master clock edge");
  a_mclk_event: assert property ($rose(mclk_lost) |-> int_status[EV_MCLK_LOSS])
    else $error("master clock loss event not recorded");

  // signal loss output and its events
  a_los_set: assert property (lost_s |=> los)
    else $error("loss output late");
  a_los_event: assert property (ev_los_set |=> int_status[EV_LOS_SET])
    else $error("loss rise event not recorded");
  a_los_clr_event: assert property (ev_los_clr |=> int_status[EV_LOS_CLR])
    else $error("loss fall event not recorded");

  // receive rails and reference ticks
  a_rail_launch: assert property (launch |=> rx_positive_rail == $past(rp_s) && rx_negative_rail == $past(rn_s))
    else $error("rails not launched on active edge");
  a_ref_tick: assert property (mclk_rise |=> mclk_ref_tick)
    else $error("reference tick missed");
  a_ref_tick_only: assert property (!mclk_rise |=> !mclk_ref_tick)
    else $error("reference tick without master clock edge");
  a_tx_tick: assert property (!next_uses_mclk && tx_line_clock_rise |=> pattern_tick && !pattern_uses_mclk)
    else $error("pattern tick missed a tx clock edge");
  a_uses_mclk_off: assert property (!next_uses_mclk |=> !pattern_uses_mclk)
    else $error("pattern reference stuck on master clock");

  // register port
  a_read_data: assert property (rd_en |=> rdata == $past(read_mux))
    else $error("read data wrong");
  a_read_idle: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_ctrl_write: assert property (ctrl_hit |=> ctrl == $past(wdata))
    else $error("control write lost");
  a_ctrl_keep: assert property (!ctrl_hit |=> $stable(ctrl))
    else $error("control changed without write");
  a_enable_write: assert property (enable_hit |=> int_enable == $past(wdata[NUM_EV-1:0]))
    else $error("enable write lost");
  a_int_sticky: assert property (1'b1 |=> (int_status & $past(int_status & ~clear_mask)) == $past(int_status & ~clear_mask))
    else $error("status bit dropped without clear");
  a_strap_hold: assert property (strap_wait == 2'h3 |=> $stable(ctrl_if_mode))
    else $error("control interface mode moved after capture");

  c_src_mclk: cover property (src_sel == RXCS_SRC_MCLK ##1 launch);
  c_src_slicer: cover property (src_sel == RXCS_SRC_SLICER ##1 launch);
  c_tx_missing: cover property ($rose(tx_clock_missing));
  c_irq_rise: cover property ($rose(irq));
  c_mclk_lost: cover property ($rose(mclk_lost));

endmodule : rxcs_top

// *** tb/rxcs_line_model.sv ***
// rxcs_line_model: line-side clock sources of the block: master reference,
// tx line clock and recovered clock; assumes the bench gates each by a run flag.
`timescale 1ns/1ps
module rxcs_line_model (
  input wire logic mclk_run,
  input wire logic tx_run,
  input wire logic rec_run,
  output logic mclk_in,
  output logic tx_line_clock,
  output logic rx_recovered_clock
);
  // a stopped source stands still at its last level, as a dead oscillator would
  initial begin
    mclk_in = 1'b0;
    #3;
    forever #244 if (mclk_run) mclk_in = ~mclk_in;
  end
  // odd offsets keep the link clocks out of phase with the system clock
  initial begin
    tx_line_clock = 1'b0;
    #7;
    forever #160 if (tx_run) tx_line_clock = ~tx_line_clock;
  end
  initial begin
    rx_recovered_clock = 1'b0;
    #11;
    forever #160 if (rec_run) rx_recovered_clock = ~rx_recovered_clock;
  end
endmodule : rxcs_line_model

// *** tb/test_rxcs_top.sv ***
// test_rxcs_top: scenario bench of the rx clock source and signal loss block.
// assumes the line model makes the clocks; straps change only inside reset.
`timescale 1ns/1ps
`define CHK(n, e, g) begin #1; samples_checked++; if ((g) !== (e)) begin $display("[ERR] %s exp %h got %h", n, e, g); err_count++; end end
module test_rxcs_top import rxcs_pkg::*; ;
  localparam int LOSS = 20;
  logic clock, resetn, wr_en, rd_en, rx_signal_lost, rx_data_in, rx_positive_rail_in, rx_negative_rail_in;
  logic rx_edge_select, auto_all_ones_send, all_ones_alarm, transmit_all_ones, prbs_send, mclk_run, tx_run, rec_run;
  logic [3:0] addr;
  logic [7:0] wdata, rd_v;
  logic [1:0] ctrl_if_select;
  wire logic [7:0] rdata;
  wire logic irq, mclk_in, tx_line_clock, rx_recovered_clock, rx_clock, rx_data, rx_positive_rail, rx_negative_rail;
  wire logic los, tx_clock_missing, mclk_lost, tx_line_oe, mclk_ref_tick, pattern_tick, pattern_uses_mclk;
  rxcs_ctrl_if_t ctrl_if_mode;
  int err_count, samples_checked;
  rxcs_line_model line (.mclk_run, .tx_run, .rec_run, .mclk_in, .tx_line_clock, .rx_recovered_clock);
  rxcs_top #(.MCLK_LOSS(LOSS)) uut (.clock, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq, .mclk_in,
    .tx_line_clock, .rx_recovered_clock, .rx_signal_lost, .rx_data_in, .rx_positive_rail_in, .rx_negative_rail_in,
    .ctrl_if_select, .rx_edge_select, .auto_all_ones_send, .all_ones_alarm, .transmit_all_ones, .prbs_send,
    .rx_clock, .rx_data, .rx_positive_rail, .rx_negative_rail, .los, .tx_clock_missing, .mclk_lost, .tx_line_oe,
    .ctrl_if_mode, .mclk_ref_tick, .pattern_tick, .pattern_uses_mclk);
  always #20 clock = ~clock;
  task summarize;
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd
  // bounded wait for n rising edges of the master reference
  task mrise(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (mclk_in !== 1'b0 && k < 40) begin cyc(1); k++; end
      while (mclk_in !== 1'b1 && k < 40) begin cyc(1); k++; end
      if (k >= 40) begin err_count++; summarize(); end
    end
  endtask : mrise
  task t_strap;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      resetn <= 1'b0;
      ctrl_if_select <= 2'(3 - i);
      cyc(20);
      resetn <= 1'b1;
      cyc(4);
      `CHK("ctrl_if_mode", rxcs_ctrl_if_t'(3 - i), ctrl_if_mode)
    end
    `CHK("tx_line_oe", 1'b1, tx_line_oe)
    rd(ADDR_CTRL);
    `CHK("ctrl", CTRL_RESET, rd_v)
    wr(ADDR_CTRL, 8'ha4);
    rd(ADDR_CTRL);
    `CHK("ctrl", 8'ha4, rd_v)
    rd(4'hf);
    `CHK("unmapped", 8'h00, rd_v)
    wr(ADDR_CTRL, 8'h00);
  endtask : t_strap
  // data may move only on the active rx clock edge, rising for pin low;
  // in hardware mode the ctrl falling-edge bit must not override the pin
  task t_data;
    logic pc, pd, pp, pn;
    int bad, moves;
    for (int e = 0; e < 3; e++) begin
      cyc(1);
      rx_edge_select <= e[0];
      if (e == 2) wr(ADDR_CTRL, 8'h08);
      cyc(6);
      bad = 0;
      moves = 0;
      for (int k = 0; k < 60; k++) begin
        // a period of 6 against the 8-cycle rx clock varies the launched value
        if (k % 3 == 0) begin
          rx_data_in <= ~rx_data_in;
          rx_positive_rail_in <= ~rx_positive_rail_in;
          rx_negative_rail_in <= ~rx_negative_rail_in;
        end
        #1;
        if (k > 0 && (rx_data !== pd || rx_positive_rail !== pp || rx_negative_rail !== pn)) begin
          moves++;
          if (rx_clock === pc || rx_clock !== !e[0]) bad++;
        end
        pc = rx_clock;
        pd = rx_data;
        pp = rx_positive_rail;
        pn = rx_negative_rail;
        cyc(1);
      end
      `CHK("data_moves", 1'b1, moves > 0)
      `CHK("off_edge_moves", 0, bad)
    end
    wr(ADDR_CTRL, 8'h00);
  endtask : t_data
  task t_source;
    repeat (2) begin
      rec_run <= 1'b1;
      cyc(4);
      rec_run <= 1'b0;
      cyc(6);
      `CHK("rx_clock_rec", rx_recovered_clock, rx_clock)
    end
    wr(ADDR_CTRL, 8'h02);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      rx_positive_rail_in <= i[0];
      rx_negative_rail_in <= i[1];
      cyc(4);
      `CHK("rx_clock_xor", i[0] ^ i[1], rx_clock)
    end
    wr(ADDR_INT_ENABLE, 8'h03);
    wr(ADDR_INT_CLEAR, 8'h0f);
    rx_signal_lost <= 1'b1;
    wr(ADDR_CTRL, 8'h03);
    mrise(1);
    cyc(4);
    `CHK("rx_clock_mclk_hi", 1'b1, rx_clock)
    cyc(6);
    `CHK("rx_clock_mclk_lo", 1'b0, rx_clock)
    `CHK("los_high", 1'b1, los)
    `CHK("irq_on", 1'b1, irq)
    rd(ADDR_INT_STATUS);
    `CHK("int_los_rise", 2'b01, rd_v[1:0])
    wr(ADDR_INT_ENABLE, 8'h00);
    cyc(2);
    `CHK("irq_masked", 1'b0, irq)
    wr(ADDR_INT_ENABLE, 8'h01);
    wr(ADDR_INT_CLEAR, 8'h01);
    cyc(2);
    `CHK("irq_cleared", 1'b0, irq)
    cyc(1);
    rx_signal_lost <= 1'b0;
    cyc(5);
    `CHK("los_low", 1'b0, los)
    rd(ADDR_INT_STATUS);
    `CHK("int_los_fall", 2'b10, rd_v[1:0])
    wr(ADDR_CTRL, 8'h00);
  endtask : t_source
  task t_tx;
    tx_run <= 1'b0;
    mrise(69);
    cyc(1);
    `CHK("tx_missing_early", 1'b0, tx_clock_missing)
    mrise(3);
    cyc(5);
    `CHK("tx_missing", 1'b1, tx_clock_missing)
    rd(ADDR_STATUS);
    `CHK("status_tx_missing", 1'b1, rd_v[1])
    rd(ADDR_INT_STATUS);
    `CHK("int_tx_miss", 1'b1, rd_v[EV_TX_MISS])
    tx_run <= 1'b1;
    cyc(12);
    `CHK("tx_back", 1'b0, tx_clock_missing)
  endtask : t_tx
  // tick counts against mclk rises seen here, one off at the window ends
  task t_patt;
    int nm, nt, np;
    logic pm;
    wr(ADDR_CTRL, 8'h04);
    cyc(3);
    `CHK("patt_ctrl", 1'b1, pattern_uses_mclk)
    nm = 0;
    nt = 0;
    np = 0;
    repeat (80) begin
      pm = mclk_in;
      cyc(1);
      #1;
      nm += int'(!pm && mclk_in);
      nt += int'(mclk_ref_tick);
      np += int'(pattern_tick);
    end
    `CHK("ref_ticks", 1'b1, nt >= nm - 1 && nt <= nm + 1)
    `CHK("patt_ticks", 1'b1, np >= nm - 1 && np <= nm + 1)
    wr(ADDR_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      {prbs_send, transmit_all_ones, all_ones_alarm, auto_all_ones_send} <= 4'(1 << i);
      cyc(2);
      `CHK("patt_forced", i < 4, pattern_uses_mclk)
    end
  endtask : t_patt
  task t_mloss;
    mclk_run <= 1'b0;
    cyc(LOSS + 6);
    `CHK("mclk_lost", 1'b1, mclk_lost)
    `CHK("tx_line_oe_off", 1'b0, tx_line_oe)
    rd(ADDR_STATUS);
    `CHK("status_mclk_lost", 1'b1, rd_v[2])
    rd(ADDR_INT_STATUS);
    `CHK("int_mclk_lost", 1'b1, rd_v[EV_MCLK_LOSS])
  endtask : t_mloss
  initial begin
    {clock, resetn, wr_en, rd_en, rx_signal_lost, rx_data_in, rx_positive_rail_in, rx_negative_rail_in} = 8'h00;
    {rx_edge_select, auto_all_ones_send, all_ones_alarm, transmit_all_ones, prbs_send} = 5'h00;
    {mclk_run, tx_run, rec_run} = 3'h7;
    addr = 4'h0;
    wdata = 8'h00;
    ctrl_if_select = 2'h0;
    err_count = 0;
    samples_checked = 0;
    t_strap();
    t_data();
    t_source();
    t_tx();
    t_patt();
    t_mloss();
    summarize();
  end
endmodule : test_rxcs_top
